//--- core/dscp_pkg.sv
package dscp_pkg;

    // ----------------------------------------------------------------
    // Core clock and timing
    // ----------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 40;
    // Time allowed for the last shifted byte to cross after select rises
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] SETTLE_LOAD = 3'(SETTLE_CYCLES);

    // ----------------------------------------------------------------
    // Three-wire word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int BURST_MAX = 9;
    localparam logic [6:0] CNT_FIRST_WORD = 7'h0F;
    localparam logic [6:0] CNT_LAST_BYTE = 7'(15 + BURST_MAX * 8);
    localparam logic [6:0] CNT_SATURATE = 7'(16 + BURST_MAX * 8);
    localparam logic [2:0] CNT_BYTE_END = 3'h7;
    localparam int DIR_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int BANK_BIT = 4;

    // ----------------------------------------------------------------
    // Register file and two-wire index space
    // ----------------------------------------------------------------
    localparam int REG_COUNT = 16;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] TW_BANK = 4'h4;
    localparam logic [7:0] TW_WRAP_HIGH = 8'h4F;
    localparam logic [7:0] TW_WRAP_LOW = 8'h40;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [7:0] data;
    } dscp_wr_t;

    typedef struct packed {
        logic [6:0] bit_cnt;
        logic [14:0] shreg;
        logic [6:0] addr;
        logic refuse;
    } dscp_shift_t;

    typedef struct packed {
        logic toggle;
        logic [6:0] addr;
        logic [7:0] data;
    } dscp_hold_t;

    typedef enum logic [3:0] {
        TW_IDLE,
        TW_ADDR,
        TW_ACK_ADDR,
        TW_REG,
        TW_ACK_REG,
        TW_WDATA,
        TW_ACK_WDATA,
        TW_RDATA,
        TW_ACK_RDATA,
        TW_IGNORE
    } dscp_tw_state_t;

endpackage

//--- core/dscp_sync.sv
`timescale 1ns/1ps

// Two flip-flop synchroniser for asynchronous levels
module dscp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk, // Destination clock
    input wire logic [WIDTH-1:0] i_async, // Foreign levels
    output logic [WIDTH-1:0] o_sync // Levels in the clock domain
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage read only by the second; no reset, so straps pass while reset is held
    always_ff @(posedge i_core_clk) begin
        meta_r <= i_async;
        sync_r <= meta_r;
    end

    assign o_sync = sync_r;
endmodule

//--- core/dscp_port.sv
`timescale 1ns/1ps

module dscp_port #(
    parameter logic [4:0] DEV_CODE = 5'h0A // Arbitrary device code
) (
    input wire logic i_core_clk, // Core clock, 40 MHz
    input wire logic i_reset, // Reset, active high; synchronous in the core domain, asynchronous for the shift side registers
    input wire logic i_port_shift_clock, // Shift clock, also two-wire bus clock
    input wire logic i_port_serial_in, // Serial data in, also two-wire data in
    input wire logic i_port_select, // Select, also slave_strap_low
    input wire logic i_address_bit_five, // Strap, also slave_strap_high
    input wire logic i_interface_mode, // 1 selects three-wire mode
    input wire logic i_address_bit_six, // Three-wire address bit six strap
    output logic o_sda_out, // Two-wire data out level
    output logic o_sda_oe_n, // Two-wire data enable, low drives
    output logic o_three_wire, // Captured interface mode
    output dscp_pkg::dscp_wr_t o_write, // One-cycle register write report
    output logic [dscp_pkg::REG_COUNT-1:0][7:0] o_regs // Register contents
);

    // ----------------------------------------------------------------
    // Shift clock domain
    // ----------------------------------------------------------------
    dscp_pkg::dscp_shift_t sh_r;
    dscp_pkg::dscp_shift_t sh_nxt;
    dscp_pkg::dscp_hold_t hold_r;
    dscp_pkg::dscp_hold_t hold_nxt;
    logic [15:0] word;
    logic shift_clr;

    // Select high ends the frame, so it clears the shifter directly
    assign shift_clr = i_port_select | i_reset;
    assign word = {sh_r.shreg, i_port_serial_in};

    // Bit counting, word split and burst addressing
    always_comb begin
        sh_nxt = sh_r;
        hold_nxt = hold_r;
        sh_nxt.shreg = word[14:0];
        if (sh_r.bit_cnt != dscp_pkg::CNT_SATURATE) begin
            sh_nxt.bit_cnt = sh_r.bit_cnt + 7'h01;
        end
        if (sh_r.bit_cnt == dscp_pkg::CNT_FIRST_WORD) begin
            sh_nxt.addr = word[dscp_pkg::ADDR_MSB:dscp_pkg::ADDR_LSB];
            sh_nxt.refuse = word[dscp_pkg::DIR_BIT];
            if (!word[dscp_pkg::DIR_BIT]) begin
                hold_nxt = {~hold_r.toggle, word[dscp_pkg::ADDR_MSB:dscp_pkg::ADDR_LSB], word[7:0]};
            end
        end else if (sh_r.bit_cnt > dscp_pkg::CNT_FIRST_WORD && sh_r.bit_cnt <= dscp_pkg::CNT_LAST_BYTE &&
                     sh_r.bit_cnt[2:0] == dscp_pkg::CNT_BYTE_END) begin
            sh_nxt.addr = sh_r.addr + 7'h01;
            if (!sh_r.refuse) begin
                hold_nxt = {~hold_r.toggle, sh_r.addr + 7'h01, word[7:0]};
            end
        end
    end

    // Shifter state, cleared whenever select is high
    always_ff @(posedge i_port_shift_clock or posedge shift_clr) begin
        if (shift_clr) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // Published byte, stable for a whole byte time after each toggle
    always_ff @(posedge i_port_shift_clock or posedge i_reset) begin
        if (i_reset) begin
            hold_r <= '0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers into the core domain
    // ----------------------------------------------------------------
    logic [6:0] pins_sync;
    logic sel_s;
    logic scl_s;
    logic sda_s;
    logic strap5_s;
    logic mode_s;
    logic bit6_s;
    logic tog_s;

    dscp_sync #(
        .WIDTH(7)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_async({i_port_select, i_port_shift_clock, i_port_serial_in, i_address_bit_five,
                  i_interface_mode, i_address_bit_six, hold_r.toggle}),
        .o_sync(pins_sync)
    );

    assign {sel_s, scl_s, sda_s, strap5_s, mode_s, bit6_s, tog_s} = pins_sync;

    // ----------------------------------------------------------------
    // Core domain state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic three_wire;
        logic bit6;
        logic tog_seen;
        logic sel_prev;
        logic pend_valid;
        logic [6:0] pend_addr;
        logic [7:0] pend_data;
        logic [2:0] settle;
        dscp_pkg::dscp_tw_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic rw;
        logic acked;
        logic [7:0] idx;
        logic drive;
        logic scl_prev;
        logic sda_prev;
        dscp_pkg::dscp_wr_t wr;
        logic [dscp_pkg::REG_COUNT-1:0][7:0] regs;
    } dscp_core_t;

    dscp_core_t c_r;
    dscp_core_t c_nxt;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [6:0] my_addr;

    // Bus events seen on synchronised pins
    assign scl_rise = scl_s & ~c_r.scl_prev;
    assign scl_fall = ~scl_s & c_r.scl_prev;
    assign bus_start = scl_s & c_r.scl_prev & c_r.sda_prev & ~sda_s;
    assign bus_stop = scl_s & c_r.scl_prev & ~c_r.sda_prev & sda_s;
    assign my_addr = {DEV_CODE, strap5_s, sel_s};

    // Index is backed by a register only inside the two-wire bank
    function automatic logic idx_defined(input logic [7:0] idx);
        idx_defined = (idx[7:4] == dscp_pkg::TW_BANK);
    endfunction

    // Index step with bank wrap
    function automatic logic [7:0] idx_next(input logic [7:0] idx);
        if (idx == dscp_pkg::TW_WRAP_HIGH) begin
            idx_next = dscp_pkg::TW_WRAP_LOW;
        end else begin
            idx_next = idx + 8'h01;
        end
    endfunction

    // Next core state: three-wire commit and two-wire slave
    always_comb begin
        c_nxt = c_r;
        c_nxt.wr = '0;
        c_nxt.sel_prev = sel_s;
        c_nxt.scl_prev = scl_s;
        c_nxt.sda_prev = sda_s;

        if (c_r.three_wire) begin
            // Newer byte proves the pending one complete; commit it first
            if (tog_s != c_r.tog_seen) begin
                c_nxt.tog_seen = tog_s;
                c_nxt.pend_valid = 1'b1;
                c_nxt.pend_addr = hold_r.addr;
                c_nxt.pend_data = hold_r.data;
                if (c_r.settle != 3'h0) begin
                    c_nxt.settle = dscp_pkg::SETTLE_LOAD;
                end
                if (c_r.pend_valid && c_r.pend_addr[6:5] == {c_r.bit6, strap5_s} &&
                    c_r.pend_addr[dscp_pkg::BANK_BIT]) begin
                    c_nxt.regs[c_r.pend_addr[3:0]] = c_r.pend_data;
                    c_nxt.wr = {1'b1, c_r.pend_addr[3:0], c_r.pend_data};
                end
            end else if (c_r.settle != 3'h0) begin
                c_nxt.settle = c_r.settle - 3'h1;
                // Last byte of the frame is latched once select has risen
                if (c_r.settle == 3'h1) begin
                    c_nxt.pend_valid = 1'b0;
                    if (c_r.pend_valid && c_r.pend_addr[6:5] == {c_r.bit6, strap5_s} &&
                        c_r.pend_addr[dscp_pkg::BANK_BIT]) begin
                        c_nxt.regs[c_r.pend_addr[3:0]] = c_r.pend_data;
                        c_nxt.wr = {1'b1, c_r.pend_addr[3:0], c_r.pend_data};
                    end
                end
            end
            if (sel_s && !c_r.sel_prev) begin
                c_nxt.settle = dscp_pkg::SETTLE_LOAD;
            end
        end else if (bus_start) begin
            // Start or repeated start restarts address reception
            c_nxt.st = dscp_pkg::TW_ADDR;
            c_nxt.bit_cnt = 4'h0;
            c_nxt.drive = 1'b0;
        end else if (bus_stop) begin
            c_nxt.st = dscp_pkg::TW_IDLE;
            c_nxt.drive = 1'b0;
        end else begin
            case (c_r.st)
                dscp_pkg::TW_ADDR, dscp_pkg::TW_REG, dscp_pkg::TW_WDATA: begin
                    if (scl_rise) begin
                        c_nxt.shreg = {c_r.shreg[6:0], sda_s};
                        c_nxt.bit_cnt = c_r.bit_cnt + 4'h1;
                    end else if (scl_fall && c_r.bit_cnt == dscp_pkg::BITS_PER_BYTE) begin
                        c_nxt.bit_cnt = 4'h0;
                        c_nxt.st = dscp_pkg::TW_IGNORE;
                        if (c_r.st == dscp_pkg::TW_ADDR) begin
                            // Own address only; reads need a defined index
                            if (c_r.shreg[7:1] == my_addr &&
                                (!c_r.shreg[0] || idx_defined(c_r.idx))) begin
                                c_nxt.rw = c_r.shreg[0];
                                c_nxt.drive = 1'b1;
                                c_nxt.st = dscp_pkg::TW_ACK_ADDR;
                            end
                        end else if (c_r.st == dscp_pkg::TW_REG) begin
                            c_nxt.idx = c_r.shreg;
                            if (idx_defined(c_r.shreg)) begin
                                c_nxt.drive = 1'b1;
                                c_nxt.st = dscp_pkg::TW_ACK_REG;
                            end
                        end else if (idx_defined(c_r.idx)) begin
                            c_nxt.regs[c_r.idx[3:0]] = c_r.shreg;
                            c_nxt.wr = {1'b1, c_r.idx[3:0], c_r.shreg};
                            c_nxt.idx = idx_next(c_r.idx);
                            c_nxt.drive = 1'b1;
                            c_nxt.st = dscp_pkg::TW_ACK_WDATA;
                        end
                    end
                end
                dscp_pkg::TW_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (c_r.rw) begin
                            // Transmit the byte the index points to
                            c_nxt.shreg = c_r.regs[c_r.idx[3:0]];
                            c_nxt.drive = ~c_r.regs[c_r.idx[3:0]][7];
                            c_nxt.st = dscp_pkg::TW_RDATA;
                        end else begin
                            c_nxt.drive = 1'b0;
                            c_nxt.st = dscp_pkg::TW_REG;
                        end
                    end
                end
                dscp_pkg::TW_ACK_REG, dscp_pkg::TW_ACK_WDATA: begin
                    if (scl_fall) begin
                        c_nxt.drive = 1'b0;
                        c_nxt.st = dscp_pkg::TW_WDATA;
                    end
                end
                dscp_pkg::TW_RDATA: begin
                    if (scl_fall) begin
                        c_nxt.bit_cnt = c_r.bit_cnt + 4'h1;
                        if (c_r.bit_cnt + 4'h1 == dscp_pkg::BITS_PER_BYTE) begin
                            c_nxt.drive = 1'b0;
                            c_nxt.bit_cnt = 4'h0;
                            c_nxt.acked = 1'b0;
                            c_nxt.idx = idx_next(c_r.idx);
                            c_nxt.st = dscp_pkg::TW_ACK_RDATA;
                        end else begin
                            c_nxt.shreg = {c_r.shreg[6:0], 1'b0};
                            c_nxt.drive = ~c_r.shreg[6];
                        end
                    end
                end
                dscp_pkg::TW_ACK_RDATA: begin
                    if (scl_rise) begin
                        c_nxt.acked = ~sda_s;
                    end else if (scl_fall) begin
                        // No acknowledge ends the read until the next start or stop
                        if (c_r.acked && idx_defined(c_r.idx)) begin
                            c_nxt.shreg = c_r.regs[c_r.idx[3:0]];
                            c_nxt.drive = ~c_r.regs[c_r.idx[3:0]][7];
                            c_nxt.st = dscp_pkg::TW_RDATA;
                        end else begin
                            c_nxt.st = dscp_pkg::TW_IGNORE;
                        end
                    end
                end
                dscp_pkg::TW_IDLE, dscp_pkg::TW_IGNORE: begin
                    c_nxt.drive = 1'b0;
                end
                default: begin
                    c_nxt.st = dscp_pkg::TW_IDLE;
                    c_nxt.drive = 1'b0;
                end
            endcase
        end
    end

    // Core registers; mode and bit six straps are caught while reset is held
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            c_r <= '0;
            c_r.three_wire <= mode_s;
            c_r.bit6 <= bit6_s;
            c_r.tog_seen <= tog_s;
            c_r.sel_prev <= 1'b1;
            c_r.scl_prev <= 1'b1;
            c_r.sda_prev <= 1'b1;
            c_r.st <= dscp_pkg::TW_IDLE;
            c_r.regs <= {dscp_pkg::REG_COUNT{dscp_pkg::REG_RESET}};
        end else begin
            c_r <= c_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open-drain data pin: only ever pulls low, bus clock is input only
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = ~c_r.drive;
    assign o_three_wire = c_r.three_wire;
    assign o_write = c_r.wr;
    assign o_regs = c_r.regs;

endmodule

//--- bench/dscp_checker.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port behaviour checks on the core clock
// ----------------------------------------------------------------
module dscp_checker (
    input wire logic i_core_clk, // Core clock
    input wire logic i_reset, // Synchronous reset
    input wire logic i_port_shift_clock, // Shift clock or bus clock
    input wire logic i_port_serial_in, // Serial data wire
    input wire logic i_port_select, // Select or strap
    input wire logic i_address_bit_five, // Strap
    input wire logic i_interface_mode, // Mode pin
    input wire logic i_address_bit_six, // Strap
    input wire logic o_sda_out, // Data out level
    input wire logic o_sda_oe_n, // Data enable, low drives
    input wire logic o_three_wire, // Captured mode
    input wire dscp_pkg::dscp_wr_t o_write, // Write report
    input wire logic [dscp_pkg::REG_COUNT-1:0][7:0] o_regs // Register file
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_sda_out_low: assert property (o_sda_out == 1'b0)
        else $error("data out level not low");
    a_mode_frozen: assert property (($past(i_reset) == 1'b0) |-> $stable(o_three_wire))
        else $error("mode changed outside reset");
    a_write_single: assert property (o_write.valid |=> !o_write.valid)
        else $error("write report longer than one cycle");
    a_write_lands: assert property (o_write.valid |-> o_regs[o_write.index] == o_write.data)
        else $error("reported byte not in register file");
    a_regs_by_write: assert property ($changed(o_regs) |-> o_write.valid)
        else $error("register file changed without a write");
    a_three_quiet: assert property (o_three_wire |-> o_sda_oe_n)
        else $error("data line driven in three-wire mode");
    a_ack_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_port_shift_clock)
        else $error("data line moved while bus clock high");
    a_ack_on_write: assert property (o_write.valid && !o_three_wire |-> ##[0:3] !o_sda_oe_n)
        else $error("two-wire write without acknowledge");

    c_three_write: cover property (o_write.valid && o_three_wire);
    c_two_write: cover property (o_write.valid && !o_three_wire);
    c_ack: cover property ($fell(o_sda_oe_n));
endmodule

//--- bench/dscp_host.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host model: three-wire writer and two-wire bus master
// ----------------------------------------------------------------
module dscp_host (
    input wire logic i_link_clk, // Link base clock
    input wire logic i_sda, // Resolved data wire
    output logic o_sck, // Shift clock or bus clock
    output logic o_sd, // Data drive, 0 pulls the wire low
    output logic o_sel // Select, idle high
);
    initial begin
        o_sck = 1'b0;
        o_sd = 1'b1;
        o_sel = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_link_clk);
    endtask

    // Shift n bits MSB first, 120 ns per clock, clock still outside frames
    task automatic frame(input logic [87:0] bits, input int n);
        wt(1);
        o_sel <= 1'b0;
        wt(3);
        for (int i = 0; i < n; i++) begin
            o_sd <= bits[87-i];
            wt(4);
            o_sck <= 1'b1;
            wt(4);
            o_sck <= 1'b0;
        end
        wt(2);
        o_sel <= 1'b1;
        o_sd <= ~o_sd; // Released line shows no stale value
        wt(30);
    endtask

    // Start or repeated start
    task automatic start();
        wt(1);
        o_sd <= 1'b1;
        wt(20);
        o_sck <= 1'b1;
        wt(45);
        o_sd <= 1'b0;
        wt(45);
        o_sck <= 1'b0;
        wt(10);
    endtask

    task automatic stop();
        o_sd <= 1'b0;
        wt(20);
        o_sck <= 1'b1;
        wt(45);
        o_sd <= 1'b1;
        wt(90);
    endtask

    // Eight bits plus acknowledge slot, MSB first, sampled late in clock high
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            o_sd <= tx[i];
            wt(80);
            o_sck <= 1'b1;
            wt(40);
            rx[i] = i_sda;
            o_sck <= 1'b0;
            wt(10);
        end
    endtask
endmodule

//--- bench/dual_serial_control_port_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module dual_serial_control_port_bench;
    logic i_core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic i_reset; // Unknown until the first reset, whose rising edge clears the shift side
    logic mode = 1'b1;
    logic six = 1'b0;
    logic five = 1'b1;
    logic sck, sd, sel, sda, sda_out, sda_oe_n, three_wire;
    dscp_pkg::dscp_wr_t wr;
    logic [dscp_pkg::REG_COUNT-1:0][7:0] regs;
    logic [11:0] expq[$];
    logic [11:0] exp_w;
    logic [7:0] d [0:9];
    logic [87:0] fb;
    logic [8:0] rx;
    logic [15:0] bad [0:3] = '{16'hB5AA, 16'h1555, 16'h2555, 16'h7555};
    int errors = 0;
    int check_count = 0;
    integer seed = 52238;

    // Open-drain data wire with pull-up
    assign sda = sd & sda_oe_n;

    dscp_port dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_port_shift_clock(sck),
        .i_port_serial_in(sda), .i_port_select(sel), .i_address_bit_five(five),
        .i_interface_mode(mode), .i_address_bit_six(six), .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n), .o_three_wire(three_wire), .o_write(wr), .o_regs(regs));
    dscp_host host (.i_link_clk(link_clk), .i_sda(sda), .o_sck(sck), .o_sd(sd), .o_sel(sel));

    initial forever #12.5 i_core_clk = ~i_core_clk;
    initial begin
        #3.7;
        forever #7.5 link_clk = ~link_clk;
    end

    // Each write report takes the oldest expectation off the queue
    always @(posedge i_core_clk) begin
        if (wr.valid === 1'b1) begin
            `CHK(expq.size() != 0, 1'b1)
            if (expq.size() != 0) begin
                exp_w = expq.pop_front();
                `CHK({wr.index, wr.data}, exp_w)
            end
        end
    end

    task automatic do_reset(input logic m, input logic f, input logic s);
        @(posedge i_core_clk) #1;
        mode = m;
        five = f;
        six = s;
        i_reset = 1'b1;
        repeat (6) @(posedge i_core_clk);
        #1 i_reset = 1'b0;
        repeat (4) @(posedge i_core_clk);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #1500000;
        errors++;
        end_of_test();
    end

    initial begin
        // Three-wire mode, straps six=0 five=1: accepted range 0x30..0x3F
        do_reset(1'b1, 1'b1, 1'b0);
        `CHK(three_wire, 1'b1)
        for (int k = 0; k < 10; k++) d[k] = 8'($random(seed));
        expq.push_back({4'h5, d[0]});
        host.frame({1'b0, 7'h35, d[0], 72'h0}, 16);
        // Full burst from 0x37: the tenth byte lands at 0x40, outside the range
        fb = {1'b0, 7'h37, 80'h0};
        for (int k = 0; k < 10; k++) begin
            fb[79-8*k -: 8] = d[k];
            if (k < 9) expq.push_back({4'(7 + k), d[k]});
        end
        host.frame(fb, 88);
        $display("three-wire write and burst done");
        // Read direction, wrong straps, lower half, cut frame: none may land
        for (int i = 0; i < 4; i++) host.frame({bad[i], 72'h0}, 16);
        host.frame({16'h3A77, 72'h0}, 12);
        expq.push_back({4'hA, d[1]});
        host.frame({1'b0, 7'h3A, d[1], 72'h0}, 16);
        `CHK(expq.size(), 0)
        // Bit six strap high, five low: accepted range 0x50..0x5F
        do_reset(1'b1, 1'b0, 1'b1);
        expq.push_back({4'h5, d[2]});
        host.frame({1'b0, 7'h55, d[2], 72'h0}, 16);
        host.frame({1'b0, 7'h35, d[3], 72'h0}, 16);
        `CHK(expq.size(), 0)
        `CHK(regs[5], d[2])
        $display("bit six strap done");
        // Mode pin change without reset is ignored
        @(posedge i_core_clk) #1 mode = 1'b0;
        repeat (8) @(posedge i_core_clk);
        `CHK(three_wire, 1'b1)
        $display("three-wire refusals done");

        // Two-wire mode, slave address {code, 0, 1}
        do_reset(1'b0, 1'b0, 1'b0);
        `CHK(three_wire, 1'b0)
        host.start();
        host.xfer({8'h52, 1'b1}, rx);
        `CHK(rx[0], 1'b0)
        host.xfer({8'h4E, 1'b1}, rx);
        `CHK(rx[0], 1'b0)
        for (int k = 0; k < 3; k++) begin
            expq.push_back({4'(14 + k), d[k]});
            host.xfer({d[k], 1'b1}, rx);
            `CHK(rx[0], 1'b0)
        end
        host.stop();
        `CHK(expq.size(), 0)
        $display("two-wire write done");
        // Combined read of 0x4F
        host.start();
        host.xfer({8'h52, 1'b1}, rx);
        host.xfer({8'h4F, 1'b1}, rx);
        host.start();
        host.xfer({8'h53, 1'b1}, rx);
        `CHK(rx[0], 1'b0)
        host.xfer({8'hFF, 1'b1}, rx);
        `CHK(rx[8:1], d[1])
        host.stop();
        $display("two-wire read done");
        // Foreign slave address and undefined index get no acknowledge
        host.start();
        host.xfer({8'h54, 1'b1}, rx);
        `CHK(rx[0], 1'b1)
        host.stop();
        host.start();
        host.xfer({8'h52, 1'b1}, rx);
        host.xfer({8'h30, 1'b1}, rx);
        `CHK(rx[0], 1'b1)
        host.stop();
        `CHK(expq.size(), 0)
        $display("two-wire refusals done");
        end_of_test();
    end
endmodule

bind dscp_port dscp_checker chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_port_shift_clock(i_port_shift_clock), .i_port_serial_in(i_port_serial_in),
    .i_port_select(i_port_select), .i_address_bit_five(i_address_bit_five),
    .i_interface_mode(i_interface_mode), .i_address_bit_six(i_address_bit_six),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_three_wire(o_three_wire),
    .o_write(o_write), .o_regs(o_regs));
